// File: pkg/bcc_pkg.sv
// constants and types shared by the battery charger control register block
package bcc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] BCC_CTRL_ONE_IDX = 8'ha8;
  localparam logic [7:0] BCC_CTRL_TWO_IDX = 8'ha9;
  localparam logic [7:0] BCC_KEY_IDX = 8'haf;
  // security key value written to unlock protected fields (arbitrary)
  localparam logic [15:0] BCC_KEY_UNLOCK = 16'h5a3c;
  // charger control one bit positions
  localparam int BCC_ENA_BIT = 15;
  localparam int BCC_END_ACT_BIT = 6;
  localparam int BCC_FAST_BIT = 5;
  localparam int BCC_THR_BIT = 4;
  localparam int BCC_NTC_BIT = 3;
  localparam int BCC_HOT_BIT = 2;
  localparam int BCC_COLD_BIT = 1;
  localparam int BCC_DIE_BIT = 0;
  // charger control two field positions
  localparam int BCC_ACTIVE_BIT = 15;
  localparam int BCC_PAUSE_BIT = 14;
  localparam int BCC_PHASE_LSB = 12;
  localparam int BCC_TIME_LSB = 8;
  localparam int BCC_MASK_BIT = 7;
  localparam int BCC_TRK_BIT = 6;
  localparam int BCC_VSEL_LSB = 4;
  localparam int BCC_ISEL_LSB = 0;
  // values after reset
  localparam logic BCC_ENA_RST = 1'b1;
  localparam logic BCC_MON_RST = 1'b1;
  localparam logic [3:0] BCC_TIME_RST = 4'hb;
  localparam logic [1:0] BCC_VSEL_RST = 2'h0;
  localparam logic [3:0] BCC_ISEL_RST = 4'h6;
  // charge phase codes
  localparam logic [1:0] BCC_PHASE_OFF = 2'h0;
  localparam logic [1:0] BCC_PHASE_TRICKLE = 2'h1;
  localparam logic [1:0] BCC_PHASE_FAST = 2'h2;
  // timing
  localparam int BCC_TIMEOUT_BASE_MIN = 60;
  localparam int BCC_TIMEOUT_STEP_MIN = 30;
  localparam int BCC_TICK_SECONDS = 2048;
  localparam longint unsigned BCC_CLK_HZ = 50_000_000;
  localparam longint unsigned BCC_TICK_CYCLES = longint'(BCC_TICK_SECONDS) * BCC_CLK_HZ;
  // one-hot charger states
  typedef enum logic [2:0] {
    BCC_ST_OFF = 3'b001,
    BCC_ST_TRICKLE = 3'b010,
    BCC_ST_FAST = 3'b100
  } bcc_state_t;
  // register selector from address decode
  typedef enum logic [1:0] {
    BCC_SEL_NONE = 2'h0,
    BCC_SEL_ONE = 2'h1,
    BCC_SEL_TWO = 2'h2,
    BCC_SEL_KEY = 2'h3
  } bcc_sel_t;
endpackage : bcc_pkg

// File: src/bcc_sync.sv
// three-stage synchroniser for analogue status inputs
`timescale 1ns/100ps
module bcc_sync #(
  parameter int WIDTH = 9
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } bcc_sync_st_t;

  bcc_sync_st_t st_reg;
  bcc_sync_st_t st_next;

  if (WIDTH < 1) begin : g_chk
    $error("bcc_sync: WIDTH must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////
  // s1 feeds only s2; the output moves once s2 and s3 agree
  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.q[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.q;
endmodule : bcc_sync

// File: src/bcc_regs.sv
// battery charger control and status registers with charge sequencing
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/100ps
module bcc_regs
  import bcc_pkg::*;
#(
  parameter logic [39:0] TICK_CYCLES = 40'(BCC_TICK_CYCLES)
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sm_reset,
  input wire logic fast_ready,
  input wire logic thermistor_missing_flag,
  input wire logic battery_hot,
  input wire logic battery_cold,
  input wire logic die_hot,
  input wire logic wall_adaptor_feedback,
  input wire logic line_supply,
  input wire logic supply_ok,
  input wire logic battery_low,
  input wire logic charge_done,
  output logic [1:0] charge_phase_status,
  output logic charging_active_status,
  output logic usb_throttle_active,
  output logic trickle_current_select,
  output logic [1:0] charge_voltage_select,
  output logic [3:0] fast_current_select
);
  typedef struct packed {
    logic ready;
    logic [31:0] rdata;
    logic wr_pend;
    bcc_sel_t wr_sel;
    logic ena;
    logic end_act;
    logic fast;
    logic thr;
    logic ntc;
    logic hot;
    logic cold;
    logic die;
    logic pause;
    logic [3:0] time_code;
    logic mask;
    logic trk;
    logic [1:0] vsel;
    logic [3:0] isel;
    logic unlocked;
    logic ready_seen;
    logic ended;
    bcc_state_t state;
    logic [3:0] remain;
    logic [39:0] tick;
    logic [1:0] out_phase;
    logic out_active;
    logic out_thr;
  } bcc_st_t;

  localparam bcc_st_t ST_RESET = '{
    ready: 1'b1, rdata: 32'h0, wr_pend: 1'b0, wr_sel: BCC_SEL_NONE,
    ena: BCC_ENA_RST, end_act: 1'b0, fast: 1'b0, thr: 1'b0,
    ntc: BCC_MON_RST, hot: BCC_MON_RST, cold: BCC_MON_RST, die: BCC_MON_RST,
    pause: 1'b0, time_code: BCC_TIME_RST, mask: 1'b0, trk: 1'b0,
    vsel: BCC_VSEL_RST, isel: BCC_ISEL_RST, unlocked: 1'b0, ready_seen: 1'b0,
    ended: 1'b0, state: BCC_ST_OFF, remain: 4'hc, tick: 40'h0,
    out_phase: BCC_PHASE_OFF, out_active: 1'b0, out_thr: 1'b0
  };

  if (TICK_CYCLES < 40'h2) begin : g_chk
    $error("bcc_regs: TICK_CYCLES must be at least 2");
  end

  bcc_st_t st_reg;
  bcc_st_t st_next;
  logic [8:0] sync_q;
  logic ntc_s, hot_s, cold_s, die_s, wall_s, line_s, sup_s, low_s, done_s;
  logic fault;
  logic valid;
  logic charging;
  logic tick_hit;
  logic time_wr;

  ////////////////////////////////////////////////////////////////////////
  // analogue indications come from another domain
  bcc_sync #(.WIDTH(9)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({thermistor_missing_flag, battery_hot, battery_cold, die_hot,
      wall_adaptor_feedback, line_supply, supply_ok, battery_low, charge_done}),
    .sync_out(sync_q)
  );
  assign {ntc_s, hot_s, cold_s, die_s, wall_s, line_s, sup_s, low_s, done_s} = sync_q;

  // address decode; upper address bits above the 4 KiB window are ignored
  function automatic bcc_sel_t decode_sel(input logic [31:0] a);
    bcc_sel_t s;
    s = BCC_SEL_NONE;
    if (a[11:10] == 2'h0 && a[1:0] == 2'h0) begin
      if (a[9:2] == BCC_CTRL_ONE_IDX) s = BCC_SEL_ONE;
      else if (a[9:2] == BCC_CTRL_TWO_IDX) s = BCC_SEL_TWO;
      else if (a[9:2] == BCC_KEY_IDX) s = BCC_SEL_KEY;
    end
    return s;
  endfunction : decode_sel

  // timeout code to whole 2048s units, rounded up
  function automatic logic [3:0] timeout_units(input logic [3:0] c);
    int secs;
    secs = (BCC_TIMEOUT_BASE_MIN + BCC_TIMEOUT_STEP_MIN * int'(c)) * 60;
    return 4'((secs + BCC_TICK_SECONDS - 1) / BCC_TICK_SECONDS);
  endfunction : timeout_units

  ////////////////////////////////////////////////////////////////////////
  // charging qualification from the current state
  always_comb begin
    fault = (st_reg.ntc && ntc_s)
      || (st_reg.hot && hot_s)
      || (st_reg.cold && cold_s)
      || (st_reg.die && die_s)
      || (line_s && !st_reg.mask && wall_s);
    // enable is only a request; the block decides
    valid = st_reg.ena && sup_s && !st_reg.pause && !fault
      && !st_reg.ended && st_reg.remain != 4'h0;
    charging = st_reg.state != BCC_ST_OFF;
    tick_hit = charging && st_reg.tick == TICK_CYCLES - 40'h1;
    time_wr = st_reg.wr_pend && st_reg.wr_sel == BCC_SEL_TWO && st_reg.unlocked;
  end

  ////////////////////////////////////////////////////////////////////////
  // bus writes, field updates, charger sequencing and read data
  always_comb begin
    st_next = st_reg;
    st_next.ready = 1'b1;
    // data phase of a pending write: apply hwdata
    if (st_reg.wr_pend) begin
      unique case (st_reg.wr_sel)
        BCC_SEL_ONE: begin
          st_next.ntc = hwdata[BCC_NTC_BIT];
          st_next.hot = hwdata[BCC_HOT_BIT];
          st_next.cold = hwdata[BCC_COLD_BIT];
          if (st_reg.unlocked) begin
            st_next.ena = hwdata[BCC_ENA_BIT];
            st_next.end_act = hwdata[BCC_END_ACT_BIT];
            st_next.thr = hwdata[BCC_THR_BIT];
            st_next.die = hwdata[BCC_DIE_BIT];
            if (st_reg.ready_seen) begin
              st_next.fast = hwdata[BCC_FAST_BIT];
            end
          end
        end
        BCC_SEL_TWO: begin
          st_next.pause = hwdata[BCC_PAUSE_BIT];
          if (st_reg.unlocked) begin
            st_next.time_code = hwdata[BCC_TIME_LSB +: 4];
            st_next.mask = hwdata[BCC_MASK_BIT];
            st_next.trk = hwdata[BCC_TRK_BIT];
            st_next.vsel = hwdata[BCC_VSEL_LSB +: 2];
            st_next.isel = hwdata[BCC_ISEL_LSB +: 4];
          end
        end
        BCC_SEL_KEY: begin
          st_next.unlocked = hwdata[15:0] == BCC_KEY_UNLOCK;
        end
        default: begin
        end
      endcase
    end
    // fast enable stays low until the ready signal has been seen
    if (fast_ready) begin
      st_next.ready_seen = 1'b1;
    end
    // power state machine reset of the listed fields
    if (sm_reset) begin
      st_next.end_act = 1'b0;
      st_next.fast = 1'b0;
      st_next.thr = 1'b0;
      st_next.pause = 1'b0;
      st_next.mask = 1'b0;
      st_next.ena = BCC_ENA_RST;
      st_next.ended = 1'b0;
    end
    if (!st_reg.ready_seen) begin
      st_next.fast = 1'b0;
    end
    // timeout counter: reload on write, count down while charging
    if (time_wr) begin
      st_next.remain = timeout_units(hwdata[BCC_TIME_LSB +: 4]);
      st_next.tick = 40'h0;
      st_next.ended = 1'b0;
    end else if (charging) begin
      if (tick_hit) begin
        st_next.tick = 40'h0;
        if (st_reg.remain != 4'h0) begin
          st_next.remain = st_reg.remain - 4'h1;
        end
      end else begin
        st_next.tick = st_reg.tick + 40'h1;
      end
    end
    if (!st_reg.ena) begin
      st_next.ended = 1'b0;
    end
    // completion ends the charge only when end action is zero
    if (charging && done_s && !st_reg.end_act && !sm_reset) begin
      st_next.ended = 1'b1;
    end
    // phase sequencing; fast needs enable, ready and a healthy battery
    unique case (st_reg.state)
      BCC_ST_OFF: begin
        if (valid && !st_next.ended) begin
          st_next.state = (st_reg.fast && !low_s) ? BCC_ST_FAST : BCC_ST_TRICKLE;
        end
      end
      BCC_ST_TRICKLE: begin
        if (!valid || st_next.ended) st_next.state = BCC_ST_OFF;
        else if (st_reg.fast && !low_s) st_next.state = BCC_ST_FAST;
      end
      BCC_ST_FAST: begin
        if (!valid || st_next.ended) st_next.state = BCC_ST_OFF;
        else if (low_s || !st_reg.fast) st_next.state = BCC_ST_TRICKLE;
      end
    endcase
    // status outputs follow the next state so they align with it
    unique case (st_next.state)
      BCC_ST_OFF: st_next.out_phase = BCC_PHASE_OFF;
      BCC_ST_TRICKLE: st_next.out_phase = BCC_PHASE_TRICKLE;
      BCC_ST_FAST: st_next.out_phase = BCC_PHASE_FAST;
      default: st_next.out_phase = BCC_PHASE_OFF;
    endcase
    st_next.out_active = st_next.state != BCC_ST_OFF;
    st_next.out_thr = st_reg.thr && st_next.state == BCC_ST_FAST;
    // address phase: latch writes, build read data after this cycle's write
    st_next.wr_pend = 1'b0;
    st_next.wr_sel = BCC_SEL_NONE;
    if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        st_next.wr_pend = 1'b1;
        st_next.wr_sel = decode_sel(haddr);
      end else begin
        unique case (decode_sel(haddr))
          BCC_SEL_ONE: st_next.rdata = {16'h0, st_next.ena, 8'h0, st_next.end_act, st_next.fast,
            st_next.thr, st_next.ntc, st_next.hot, st_next.cold, st_next.die};
          // timeout field reads remaining time, not the code written
          BCC_SEL_TWO: st_next.rdata = {16'h0, st_reg.out_active, st_next.pause, st_reg.out_phase,
            st_next.remain, st_next.mask, st_next.trk, st_next.vsel, st_next.isel};
          BCC_SEL_KEY: st_next.rdata = {31'h0, st_next.unlocked};
          default: st_next.rdata = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flops; response is always okay
  assign hrdata = st_reg.rdata;
  assign hreadyout = st_reg.ready;
  assign hresp = 1'b0;
  assign charge_phase_status = st_reg.out_phase;
  assign charging_active_status = st_reg.out_active;
  assign usb_throttle_active = st_reg.out_thr;
  assign trickle_current_select = st_reg.trk;
  assign charge_voltage_select = st_reg.vsel;
  assign fast_current_select = st_reg.isel;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence done_no_hold_s;
    st_reg.state != BCC_ST_OFF && done_s && !st_reg.end_act && !sm_reset;
  endsequence

  sequence locked_write_two_s;
    st_reg.wr_pend && st_reg.wr_sel == BCC_SEL_TWO && !st_reg.unlocked;
  endsequence

  fast_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !st_reg.ready_seen |-> !st_reg.fast && !st_next.fast)
    else $error("fast enable set before ready");

  phase_code_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    charge_phase_status != 2'h3 && (charging_active_status == (charge_phase_status != BCC_PHASE_OFF)))
    else $error("bad phase code or active mismatch");

  end_action_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done_no_hold_s |=> charge_phase_status == BCC_PHASE_OFF ##1 charge_phase_status == BCC_PHASE_OFF)
    else $error("charge continued after completion");

  pause_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_reg.pause |=> charge_phase_status == BCC_PHASE_OFF)
    else $error("charging while paused");

  key_block_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    locked_write_two_s |=> $stable(trickle_current_select) && $stable(fast_current_select)
      && $stable(charge_voltage_select))
    else $error("protected field changed while locked");

  smreset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sm_reset |=> !st_reg.pause && !st_reg.fast && !st_reg.end_act && !st_reg.mask && !st_reg.thr)
    else $error("state machine reset missed a field");

  request_only_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !st_reg.ena |=> !charging_active_status)
    else $error("active without enable request");

  remain_dec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick_hit && !time_wr && st_reg.remain != 4'h0 |=> st_reg.remain == $past(st_reg.remain) - 4'h1)
    else $error("remaining time did not count down");

  hot_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_reg.hot && hot_s |=> charge_phase_status == BCC_PHASE_OFF)
    else $error("charging while battery hot");

  throttle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    usb_throttle_active |-> charge_phase_status == BCC_PHASE_FAST && $past(st_reg.thr))
    else $error("throttle outside fast charge");
endmodule : bcc_regs

// File: test/bcc_regs_bench.sv
// self-checking bench for the battery charger control registers
`timescale 1ns/100ps
module bcc_regs_bench;
  import bcc_pkg::*;
  //////////////////////////////////////////////////////////////////////////////
  logic clk_sys;
  logic rst_n;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic sm_reset, fast_ready, thermistor_missing_flag, battery_hot, battery_cold, die_hot;
  logic wall_adaptor_feedback, line_supply, supply_ok, battery_low, charge_done;
  logic [1:0] charge_phase_status;
  logic charging_active_status, usb_throttle_active, trickle_current_select;
  logic [1:0] charge_voltage_select;
  logic [3:0] fast_current_select;
  int mismatches;
  int checks;
  int cycles;
  // short tick so the countdown fits the run
  localparam logic [39:0] SIM_TICK = 40'h14;
  // the single slave drives the bus ready
  assign hready = hreadyout;
  bcc_regs #(.TICK_CYCLES(SIM_TICK)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sm_reset(sm_reset), .fast_ready(fast_ready),
    .thermistor_missing_flag(thermistor_missing_flag), .battery_hot(battery_hot), .battery_cold(battery_cold),
    .die_hot(die_hot), .wall_adaptor_feedback(wall_adaptor_feedback), .line_supply(line_supply),
    .supply_ok(supply_ok), .battery_low(battery_low), .charge_done(charge_done),
    .charge_phase_status(charge_phase_status), .charging_active_status(charging_active_status),
    .usb_throttle_active(usb_throttle_active), .trickle_current_select(trickle_current_select),
    .charge_voltage_select(charge_voltage_select), .fast_current_select(fast_current_select));
  //////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      give_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t register read %h expected %h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_pin(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t output %h expected %h", $time, got, exp);
    end
  endtask : cmp_pin
  // one single transfer; called right after a rising edge, waits for ready
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    hsel <= 1'b1;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus(idx, 1'b1, d, r);
  endtask : wr
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] r;
    bus(idx, 1'b0, 32'h0, r);
    cmp_reg(r & mask, exp);
  endtask : rd_chk
  // async status inputs need the synchroniser latency plus one decision clock
  task automatic settle();
    repeat (8) @(posedge clk_sys);
  endtask : settle
  task automatic chk_phase(input logic [1:0] p);
    cmp_pin({2'h0, charge_phase_status}, {2'h0, p});
    cmp_pin({3'h0, charging_active_status}, {3'h0, (p != 2'h0)});
  endtask : chk_phase
  task automatic set_fault(input int k, input logic v);
    case (k)
      0: die_hot <= v;
      1: battery_cold <= v;
      2: battery_hot <= v;
      default: thermistor_missing_flag <= v;
    endcase
  endtask : set_fault
  //////////////////////////////////////////////////////////////////////////////
  // reset values, unmapped place, key protection and plain field outputs
  task automatic t_reset_key();
    rd_chk(BCC_CTRL_ONE_IDX, 32'hffffffff, 32'h0000800f);
    rd_chk(BCC_CTRL_TWO_IDX, 32'hffffffff, 32'h00000c06);
    rd_chk(BCC_KEY_IDX, 32'hffffffff, 32'h0);
    wr(8'h10, 32'h0000ffff);
    rd_chk(8'h10, 32'hffffffff, 32'h0);
    cmp_pin(fast_current_select, 4'h6);
    wr(BCC_CTRL_TWO_IDX, 32'h00000bf9);
    rd_chk(BCC_CTRL_TWO_IDX, 32'h000000ff, 32'h00000006);
    cmp_pin({3'h0, hresp}, 4'h0);
    wr(BCC_KEY_IDX, {16'h0, BCC_KEY_UNLOCK});
    rd_chk(BCC_KEY_IDX, 32'h00000001, 32'h1);
    for (int v = 0; v < 4; v++) begin
      // current kept at 400mA so a usb supply is never overdriven
      wr(BCC_CTRL_TWO_IDX, 32'h00000b48 | (v << 4));
      @(posedge clk_sys);
      cmp_pin({3'h0, trickle_current_select}, 4'h1);
      cmp_pin({2'h0, charge_voltage_select}, v[3:0]);
      cmp_pin(fast_current_select, 4'h8);
    end
    wr(BCC_CTRL_TWO_IDX, 32'h00000b06);
    @(posedge clk_sys);
    cmp_pin({3'h0, trickle_current_select}, 4'h0);
  endtask : t_reset_key
  // fast enable held until ready, phases, status and throttle
  task automatic t_fast();
    supply_ok <= 1'b1;
    settle();
    chk_phase(BCC_PHASE_TRICKLE);
    rd_chk(BCC_CTRL_TWO_IDX, 32'h0000f000, 32'h00009000);
    wr(BCC_CTRL_ONE_IDX, 32'h0000802f);
    rd_chk(BCC_CTRL_ONE_IDX, 32'h0000ffff, 32'h0000800f);
    fast_ready <= 1'b1;
    @(posedge clk_sys);
    fast_ready <= 1'b0;
    wr(BCC_CTRL_ONE_IDX, 32'h0000802f);
    rd_chk(BCC_CTRL_ONE_IDX, 32'h0000ffff, 32'h0000802f);
    settle();
    chk_phase(BCC_PHASE_FAST);
    rd_chk(BCC_CTRL_TWO_IDX, 32'h0000f000, 32'h0000a000);
    cmp_pin({3'h0, usb_throttle_active}, 4'h0);
    wr(BCC_CTRL_ONE_IDX, 32'h0000803f);
    repeat (2) @(posedge clk_sys);
    cmp_pin({3'h0, usb_throttle_active}, 4'h1);
    battery_low <= 1'b1;
    settle();
    chk_phase(BCC_PHASE_TRICKLE);
    cmp_pin({3'h0, usb_throttle_active}, 4'h0);
    battery_low <= 1'b0;
    settle();
    chk_phase(BCC_PHASE_FAST);
  endtask : t_fast
  // each monitor bit gates its fault input; wall feedback mask
  task automatic t_faults();
    for (int k = 0; k < 4; k++) begin
      wr(BCC_CTRL_TWO_IDX, 32'h00000b06);
      set_fault(k, 1'b1);
      settle();
      chk_phase(BCC_PHASE_OFF);
      wr(BCC_CTRL_ONE_IDX, 32'h0000803f & ~(32'h1 << k));
      settle();
      chk_phase(BCC_PHASE_FAST);
      set_fault(k, 1'b0);
      wr(BCC_CTRL_ONE_IDX, 32'h0000803f);
    end
    line_supply <= 1'b1;
    wall_adaptor_feedback <= 1'b1;
    settle();
    chk_phase(BCC_PHASE_OFF);
    wr(BCC_CTRL_TWO_IDX, 32'h00000b86);
    settle();
    chk_phase(BCC_PHASE_FAST);
    line_supply <= 1'b0;
    wall_adaptor_feedback <= 1'b0;
    wr(BCC_CTRL_TWO_IDX, 32'h00000b06);
  endtask : t_faults
  // pause and the state machine reset of the listed fields only
  task automatic t_pause_sm();
    wr(BCC_CTRL_TWO_IDX, 32'h00004b06);
    repeat (3) @(posedge clk_sys);
    chk_phase(BCC_PHASE_OFF);
    rd_chk(BCC_CTRL_TWO_IDX, 32'h00004000, 32'h00004000);
    wr(BCC_CTRL_TWO_IDX, 32'h00000b06);
    repeat (3) @(posedge clk_sys);
    chk_phase(BCC_PHASE_FAST);
    wr(BCC_CTRL_TWO_IDX, 32'h00004b86);
    wr(BCC_CTRL_ONE_IDX, 32'h0000807b);
    sm_reset <= 1'b1;
    @(posedge clk_sys);
    sm_reset <= 1'b0;
    @(posedge clk_sys);
    rd_chk(BCC_CTRL_ONE_IDX, 32'h0000ffff, 32'h0000800b);
    rd_chk(BCC_CTRL_TWO_IDX, 32'h000040ff, 32'h00000006);
    // dropping the enable request stops a running charge
    wr(BCC_CTRL_ONE_IDX, 32'h0000000f);
    repeat (3) @(posedge clk_sys);
    chk_phase(BCC_PHASE_OFF);
    rd_chk(BCC_CTRL_TWO_IDX, 32'h00008000, 32'h00000000);
    wr(BCC_CTRL_ONE_IDX, 32'h0000800f);
  endtask : t_pause_sm
  // timeout codes, remaining readback, end action and countdown
  task automatic t_timeout();
    supply_ok <= 1'b0;
    settle();
    for (int c = 0; c < 16; c++) begin
      wr(BCC_CTRL_TWO_IDX, (c << 8) | 32'h6);
      rd_chk(BCC_CTRL_TWO_IDX, 32'h00000f00, (((60 + 30 * c) * 60 + 2047) / 2048) << 8);
    end
    supply_ok <= 1'b1;
    wr(BCC_CTRL_TWO_IDX, 32'h00000b06);
    settle();
    chk_phase(BCC_PHASE_TRICKLE);
    charge_done <= 1'b1;
    settle();
    charge_done <= 1'b0;
    settle();
    chk_phase(BCC_PHASE_OFF);
    wr(BCC_CTRL_ONE_IDX, 32'h0000804f);
    wr(BCC_CTRL_TWO_IDX, 32'h00000006);
    charge_done <= 1'b1;
    settle();
    chk_phase(BCC_PHASE_TRICKLE);
    rd_chk(BCC_CTRL_TWO_IDX, 32'h00000f00, 32'h00000200);
    repeat (20) @(posedge clk_sys);
    rd_chk(BCC_CTRL_TWO_IDX, 32'h00000f00, 32'h00000100);
    repeat (30) @(posedge clk_sys);
    rd_chk(BCC_CTRL_TWO_IDX, 32'h00000f00, 32'h00000000);
    chk_phase(BCC_PHASE_OFF);
    charge_done <= 1'b0;
  endtask : t_timeout
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    {sm_reset, fast_ready, thermistor_missing_flag, battery_hot, battery_cold, die_hot} = 6'h0;
    {wall_adaptor_feedback, line_supply, supply_ok, battery_low, charge_done} = 5'h0;
    mismatches = 0;
    checks = 0;
    cycles = 0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset_key();
    t_fast();
    t_faults();
    t_pause_sm();
    t_timeout();
    give_verdict();
  end
endmodule : bcc_regs_bench
